// ---- hdl/wdt_pkg.sv ----
// Constants, register layout and shared types of the watchdog and its controller.
// Assumes one clock domain; both ends import this package.
//
// Notes on behaviour
// - Warning interval expiry raises interrupt when enabled
// - Reset interval expiry requests system reset when enabled
// - Warning interval is two to (31-field)
// - Reset interval spans two^31 down to two^16
// - Software keeps warning interval below reset interval; the bench sets both to two^16
// - Keys A5 then 5A clear the count
// - Run enable needs keys then run bit
// - Writing zero to run bit stops it
// - Only power-on reset clears run enable
// - Every reset clears the counter
// - Reset-cause flag set, survives watchdog reset
// - Reset enable cleared only by power-on; the device also clears it on a control write with bit 11 low
// - Sticky warning flag, gated interrupt, write-one clears
// - Software checks reset-cause flag after start-up
package wdt_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Device register map
   localparam logic [7:0]  WDT_CTRL_OFS  = 8'h00;
   localparam logic [7:0]  WDT_KEY_OFS   = 8'h04;
   localparam logic [31:0] WDT_CTRL_RST  = 32'h0000_0000;
   localparam logic [7:0]  WDT_KEY_RST   = 8'h00;
   localparam int          WDT_IPER_LSB  = 0;
   localparam int          WDT_RPER_LSB  = 4;
   localparam int          WDT_RUN_BIT   = 8;
   localparam int          WDT_IFLAG_BIT = 9;
   localparam int          WDT_IEN_BIT   = 10;
   localparam int          WDT_REN_BIT   = 11;
   localparam int          WDT_CAUSE_BIT = 31;
   localparam logic [7:0]  WDT_KEY_FIRST = 8'hA5;
   localparam logic [7:0]  WDT_KEY_SECOND = 8'h5A;
   localparam logic [4:0]  WDT_EXP_TOP   = 5'h1F;
   ////////////////////////////////////////////////////////////////////////////
   // Controller register map
   localparam logic [7:0]  HC_CFG_OFS    = 8'h00;
   localparam logic [7:0]  HC_CMD_OFS    = 8'h04;
   localparam logic [7:0]  HC_RES_OFS    = 8'h08;
   localparam logic [7:0]  HC_STAT_OFS   = 8'h0C;
   localparam logic [7:0]  HC_IEN_OFS    = 8'h10;
   localparam logic [7:0]  HC_ICLR_OFS   = 8'h14;
   localparam int          HC_CMD_KICK   = 0;
   localparam int          HC_CMD_EN     = 1;
   localparam int          HC_CMD_DIS    = 2;
   localparam int          HC_CMD_ICLR   = 3;
   localparam int          HC_CMD_READ   = 4;
   localparam int          HC_CMD_CCLR   = 5;
   localparam int          HC_EV_W       = 3;
   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {WDT_KEY_IDLE, WDT_KEY_HALF, WDT_KEY_OPEN} wdt_key_t;
   typedef enum logic [2:0] {HC_IDLE, HC_KEYA, HC_KEYB, HC_CTRL, HC_READ, HC_CAPT} wdt_hst_t;
endpackage

// ---- hdl/wdt_if.sv ----
// Link between the watchdog and its controller: register port and reset lines.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface wdt_if;
   logic [7:0]  addr;    // Register byte address
   logic [31:0] wdata;   // Write data
   logic        wr;      // Write strobe
   logic        rd;      // Read strobe
   logic [31:0] rdata;   // Read data, cycle after rd
   logic        irq;     // Warning interrupt level
   logic        rst_req; // System reset request pulse
   logic        sys_rst; // Non power-on reset into the device
   modport dev  (input addr, wdata, wr, rd, sys_rst, output rdata, irq, rst_req);
   modport host (output addr, wdata, wr, rd, sys_rst, input rdata, irq, rst_req);
endinterface

// ---- hdl/wdt_tmo.sv ----
// One timeout comparator: flags the cycle the count equals 2^(31-sel).
// Assumes the count advances by one per cycle from zero.
`timescale 1ns/1ns
module wdt_tmo #(
   parameter int CNT_W = 32
) (
   input  wire logic [CNT_W-1:0] count, // Running count
   input  wire logic [3:0]       sel,   // Interval select field
   input  wire logic             en,    // Counter running
   output logic                  hit    // Interval reached this cycle
);
   import wdt_pkg::*;
   logic [4:0] expo;
   // Exponent and equality
   assign expo = WDT_EXP_TOP - {1'b0, sel};
   assign hit  = en && (count == (CNT_W'(1) << expo));
endmodule

// ---- hdl/wdt_dev.sv ----
// Watchdog device end: control and restart-key registers, counter, timeouts.
// Assumes SRST is the power-on reset and LINK.sys_rst every other reset.
// The count saturates at all ones; each timeout fires once per restart.
// Run enable, reset enable and the cause flag ride through LINK.sys_rst.
// Read data stand one cycle after the strobe, zero otherwise.
`timescale 1ns/1ns
module wdt_dev #(
   parameter int CNT_W = 32
) (
   input  wire logic MCLK, // Peripheral clock, 250 MHz
   input  wire logic SRST, // Power-on reset
   wdt_if.dev        LINK  // Register port and reset lines
);
   import wdt_pkg::*;

   typedef struct packed {
      // Counter and interval selects
      logic [CNT_W-1:0] count;
      logic [3:0]       int_per;
      logic [3:0]       rst_per;

      // Enables and flags
      logic             int_en;
      logic             rst_en;
      logic             int_flag;
      logic             run_en;
      logic             cause;

      // Restart key sequencer
      logic [7:0]       key_val;
      wdt_key_t         key_st;

      // Registered link outputs
      logic [31:0]      rdata;
      logic             irq;
      logic             rst_req;
   } wdt_dev_t;

   wdt_dev_t st_reg;
   wdt_dev_t st_next;

   // Timeout hits
   logic     int_hit;
   logic     rst_hit;

   // Decoded accesses
   logic     wr_ctl;
   logic     wr_key;
   logic     rd_ctl;
   logic     rd_key;

   // Key values and control write bits
   logic     key_first;
   logic     key_second;
   logic     run_set;
   logic     flag_clr;
   logic     cause_clr;
   logic     kick;

   ////////////////////////////////////////////////////////////////////////////
   // Timeout comparators
   // Warning interval
   wdt_tmo #(.CNT_W(CNT_W)) u_int_tmo (
      .count (st_reg.count),
      .sel   (st_reg.int_per),
      .en    (st_reg.run_en),
      .hit   (int_hit)
   );

   // Reset interval
   wdt_tmo #(.CNT_W(CNT_W)) u_rst_tmo (
      .count (st_reg.count),
      .sel   (st_reg.rst_per),
      .en    (st_reg.run_en),
      .hit   (rst_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Access decode
   assign wr_ctl = LINK.wr && (LINK.addr == WDT_CTRL_OFS);
   assign wr_key = LINK.wr && (LINK.addr == WDT_KEY_OFS);
   assign rd_ctl = LINK.rd && (LINK.addr == WDT_CTRL_OFS);
   assign rd_key = LINK.rd && (LINK.addr == WDT_KEY_OFS);

   // Key values on the restart register
   assign key_first  = wr_key && (LINK.wdata[7:0] == WDT_KEY_FIRST);
   assign key_second = wr_key && (LINK.wdata[7:0] == WDT_KEY_SECOND);

   // Second key counts only straight after the first
   assign kick = key_second && (st_reg.key_st == WDT_KEY_HALF);

   // Control write bits
   assign run_set   = LINK.wdata[WDT_RUN_BIT];
   assign flag_clr  = LINK.wdata[WDT_IFLAG_BIT];
   assign cause_clr = !LINK.wdata[WDT_CAUSE_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      // Hold state; pulses and read data default low
      st_next         = st_reg;
      st_next.rst_req = 1'b0;
      st_next.rdata   = '0;

      // Counter: clears on restart, stops at all ones
      if (!st_reg.run_en || kick) begin
         st_next.count = '0;
      end else if (st_reg.count != '1) begin
         st_next.count = st_reg.count + CNT_W'(1);
      end

      // Restart key sequencer
      if (wr_key) begin
         st_next.key_val = LINK.wdata[7:0];
         if (key_first) begin
            st_next.key_st = WDT_KEY_HALF;
         end else if (kick) begin
            st_next.key_st = WDT_KEY_OPEN;
         end else begin
            st_next.key_st = WDT_KEY_IDLE;
         end
      end

      // Control write
      if (wr_ctl) begin
         st_next.int_per = LINK.wdata[WDT_IPER_LSB +: 4];
         st_next.rst_per = LINK.wdata[WDT_RPER_LSB +: 4];
         st_next.int_en  = LINK.wdata[WDT_IEN_BIT];
         st_next.rst_en  = LINK.wdata[WDT_REN_BIT];
         st_next.key_st  = WDT_KEY_IDLE;

         // Run: clear freely, set only when unlocked
         if (!run_set) begin
            st_next.run_en = 1'b0;
         end else if (st_reg.key_st == WDT_KEY_OPEN) begin
            st_next.run_en = 1'b1;
         end

         // Warning flag, write one clears
         if (flag_clr) begin
            st_next.int_flag = 1'b0;
         end

         // Cause flag, write zero clears
         if (cause_clr) begin
            st_next.cause = 1'b0;
         end
      end

      // Timeout events; set wins over a clear in the same cycle
      if (int_hit) begin
         st_next.int_flag = 1'b1;
      end

      // Reset request and cause only when enabled
      if (rst_hit && st_reg.rst_en) begin
         st_next.rst_req = 1'b1;
         st_next.cause   = 1'b1;
      end

      // Read data, one cycle after the strobe
      if (rd_ctl) begin
         // Control layout, reserved bits zero
         st_next.rdata[WDT_IPER_LSB +: 4] = st_reg.int_per;
         st_next.rdata[WDT_RPER_LSB +: 4] = st_reg.rst_per;
         st_next.rdata[WDT_RUN_BIT]       = st_reg.run_en;
         st_next.rdata[WDT_IFLAG_BIT]     = st_reg.int_flag;
         st_next.rdata[WDT_IEN_BIT]       = st_reg.int_en;
         st_next.rdata[WDT_REN_BIT]       = st_reg.rst_en;
         st_next.rdata[WDT_CAUSE_BIT]     = st_reg.cause;
      end else if (rd_key) begin
         // Key register shows the last key
         st_next.rdata[7:0] = st_reg.key_val;
      end

      // Other resets: run, reset enable and cause survive
      if (LINK.sys_rst) begin
         // Counter and configuration to reset values
         st_next.count    = '0;
         st_next.int_per  = WDT_CTRL_RST[WDT_IPER_LSB +: 4];
         st_next.rst_per  = WDT_CTRL_RST[WDT_RPER_LSB +: 4];
         st_next.int_en   = WDT_CTRL_RST[WDT_IEN_BIT];
         st_next.int_flag = WDT_CTRL_RST[WDT_IFLAG_BIT];
         // Key sequencer and link outputs
         st_next.key_val  = WDT_KEY_RST;
         st_next.key_st   = WDT_KEY_IDLE;
         st_next.rst_req  = 1'b0;
         st_next.rdata    = '0;
      end

      // Interrupt level only while enabled
      st_next.irq = st_next.int_flag && st_next.int_en;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; power-on reset clears everything
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign LINK.rdata   = st_reg.rdata;
   assign LINK.irq     = st_reg.irq;
   assign LINK.rst_req = st_reg.rst_req;
endmodule

// ---- hdl/wdt_host.sv ----
// Controller end: turns software commands into watchdog register sequences,
// acts as reset logic and interrupt collector. Assumes one shared clock.
`timescale 1ns/1ns
module wdt_host (
   input  wire logic        MCLK,  // Clock, 250 MHz
   input  wire logic        SRST,  // Synchronous reset
   input  wire logic [7:0]  ADDR,  // Software register address
   input  wire logic [31:0] WDATA, // Software write data
   input  wire logic        WR,    // Software write strobe
   input  wire logic        RD,    // Software read strobe
   output logic      [31:0] RDATA, // Software read data
   output logic             IRQ,   // Interrupt level
   wdt_if.host              LINK   // Link to the watchdog
);
   import wdt_pkg::*;

   typedef struct packed {
      wdt_hst_t            fsm;
      logic [11:0]         cfg;
      logic                do_ctrl;
      logic [31:0]         ctrl_val;
      logic [31:0]         result;
      logic [HC_EV_W-1:0]  stat;
      logic [HC_EV_W-1:0]  ien;
      logic                irq_d;
      logic [31:0]         rdata;
      logic                irq;
      logic [7:0]          addr;
      logic [31:0]         wdata;
      logic                wr;
      logic                rd;
      logic                sys_rst;
   } wdt_hst_s_t;

   wdt_hst_s_t st_reg;
   wdt_hst_s_t st_next;
   logic [HC_EV_W-1:0] ev;
   logic [31:0]        base;

   ////////////////////////////////////////////////////////////////////////////
   // Control word: configuration, reset cause kept, run bit set
   always_comb begin
      base                = {20'h0_0000, st_reg.cfg};
      base[WDT_RUN_BIT]   = 1'b1;
      base[WDT_IFLAG_BIT] = 1'b0;
      base[WDT_CAUSE_BIT] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next         = st_reg;
      st_next.wr      = 1'b0;
      st_next.rd      = 1'b0;
      st_next.sys_rst = 1'b0;
      st_next.rdata   = '0;
      st_next.irq_d   = LINK.irq;
      ev              = '0;

      // Command sequencer, at most one link access per state
      unique case (st_reg.fsm)
         HC_IDLE: begin
            if (WR && (ADDR == HC_CMD_OFS)) begin
               st_next.do_ctrl  = 1'b0;
               st_next.ctrl_val = base;
               st_next.addr     = WDT_KEY_OFS;
               st_next.wdata    = {24'h00_0000, WDT_KEY_FIRST};
               if (WDATA[HC_CMD_KICK]) begin
                  st_next.wr  = 1'b1;
                  st_next.fsm = HC_KEYA;
               end else if (WDATA[HC_CMD_EN]) begin
                  st_next.wr      = 1'b1;
                  st_next.do_ctrl = 1'b1;
                  st_next.fsm     = HC_KEYA;
               end else if (WDATA[HC_CMD_DIS] || WDATA[HC_CMD_ICLR]
                            || WDATA[HC_CMD_CCLR]) begin
                  st_next.addr  = WDT_CTRL_OFS;
                  st_next.wdata = base;
                  st_next.wdata[WDT_RUN_BIT]   = !WDATA[HC_CMD_DIS];
                  st_next.wdata[WDT_IFLAG_BIT] = WDATA[HC_CMD_ICLR];
                  st_next.wdata[WDT_CAUSE_BIT] = !WDATA[HC_CMD_CCLR];
                  st_next.wr    = 1'b1;
                  st_next.fsm   = HC_CTRL;
               end else if (WDATA[HC_CMD_READ]) begin
                  st_next.addr = WDT_CTRL_OFS;
                  st_next.rd   = 1'b1;
                  st_next.fsm  = HC_READ;
               end
            end
         end
         HC_KEYA: begin
            st_next.wdata = {24'h00_0000, WDT_KEY_SECOND};
            st_next.wr    = 1'b1;
            st_next.fsm   = HC_KEYB;
         end
         HC_KEYB: begin
            if (st_reg.do_ctrl) begin
               st_next.addr  = WDT_CTRL_OFS;
               st_next.wdata = st_reg.ctrl_val;
               st_next.wr    = 1'b1;
               st_next.fsm   = HC_CTRL;
            end else begin
               ev[2]       = 1'b1;
               st_next.fsm = HC_IDLE;
            end
         end
         HC_CTRL: begin
            ev[2]       = 1'b1;
            st_next.fsm = HC_IDLE;
         end
         HC_READ: begin
            st_next.fsm = HC_CAPT;
         end
         HC_CAPT: begin
            st_next.result = LINK.rdata;
            ev[2]          = 1'b1;
            st_next.fsm    = HC_IDLE;
         end
      endcase

      // Reset logic: request becomes a one-cycle system reset
      if (LINK.rst_req) begin
         st_next.sys_rst = 1'b1;
         ev[1]           = 1'b1;
      end
      ev[0] = LINK.irq && !st_reg.irq_d;

      // Software registers
      if (WR && (ADDR == HC_CFG_OFS)) begin
         st_next.cfg = WDATA[11:0];
      end
      if (WR && (ADDR == HC_IEN_OFS)) begin
         st_next.ien = WDATA[HC_EV_W-1:0];
      end
      if (WR && (ADDR == HC_ICLR_OFS)) begin
         st_next.stat = st_reg.stat & ~WDATA[HC_EV_W-1:0];
      end
      st_next.stat = st_next.stat | ev;
      st_next.irq  = |(st_next.stat & st_next.ien);

      // Read data, cycle after the strobe
      if (RD) begin
         unique case (ADDR)
            HC_CFG_OFS:  st_next.rdata = {20'h0_0000, st_reg.cfg};
            HC_CMD_OFS:  st_next.rdata = {31'h0000_0000, st_reg.fsm != HC_IDLE};
            HC_RES_OFS:  st_next.rdata = st_reg.result;
            HC_STAT_OFS: st_next.rdata = {{(32-HC_EV_W){1'b0}}, st_reg.stat};
            HC_IEN_OFS:  st_next.rdata = {{(32-HC_EV_W){1'b0}}, st_reg.ien};
            default:     st_next.rdata = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign RDATA        = st_reg.rdata;
   assign IRQ          = st_reg.irq;
   assign LINK.addr    = st_reg.addr;
   assign LINK.wdata   = st_reg.wdata;
   assign LINK.wr      = st_reg.wr;
   assign LINK.rd      = st_reg.rd;
   assign LINK.sys_rst = st_reg.sys_rst;
endmodule

// ---- verif/wdt_props.sv ----
// Checker for the watchdog link: reset request path, strobes, read data, interrupt.
// Assumes one clock; instantiated beside the link interface by the bench top.
`timescale 1ns/1ns
module wdt_props (
   input  wire logic        MCLK,    // Clock
   input  wire logic        SRST,    // Power-on reset
   input  wire logic [7:0]  addr,    // Register address
   input  wire logic [31:0] wdata,   // Write data
   input  wire logic        wr,      // Write strobe
   input  wire logic        rd,      // Read strobe
   input  wire logic [31:0] rdata,   // Read data
   input  wire logic        irq,     // Interrupt level
   input  wire logic        rst_req, // Reset request pulse
   input  wire logic        sys_rst  // Non power-on reset
);
   import wdt_pkg::*;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   ////////////////////////////////////////////////////////////////////////////
   // Reset request path
   AST_SYS_FOLLOWS: assert property (rst_req |=> sys_rst)
      else $error("reset request not followed by system reset");
   AST_REQ_ONCE: assert property (rst_req |=> !rst_req)
      else $error("reset request longer than one cycle");
   AST_SYS_CAUSE: assert property ($rose(sys_rst) |-> $past(rst_req))
      else $error("system reset without a request");
   AST_SYS_IRQ: assert property (sys_rst |-> ##2 !irq)
      else $error("interrupt survives system reset");
   ////////////////////////////////////////////////////////////////////////////
   // Register port
   AST_NO_BOTH: assert property (!(wr && rd))
      else $error("write and read strobes together");
   AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   AST_KEY_PAIR: assert property (wr && addr == WDT_KEY_OFS && wdata[7:0] == WDT_KEY_FIRST
      |=> wr && addr == WDT_KEY_OFS && wdata[7:0] == WDT_KEY_SECOND)
      else $error("first key not followed by second key");
   AST_FLAG_CLR: assert property (wr && addr == WDT_CTRL_OFS && wdata[9] |-> ##2 !irq)
      else $error("interrupt stays after flag clear");
   AST_RSVD: assert property ($past(rd) && $past(addr) == WDT_CTRL_OFS
      |-> rdata[30:12] == 19'h0_0000)
      else $error("reserved control bits read non zero");
   // Main scenarios reached
   COV_REQ: cover property (rst_req);
   COV_RUN: cover property (wr && addr == WDT_CTRL_OFS && wdata[8]);
   COV_IRQ: cover property ($rose(irq));
endmodule

// ---- verif/wdt_tb.sv ----
// Bench for watchdog plus controller: software port driven, link watched.
// Assumes the package, link interface, both ends and the checker are compiled first.
`timescale 1ns/1ns
module wdt_tb;
   import wdt_pkg::*;
   logic        MCLK      = 1'b0;
   logic        SRST      = 1'b1;
   logic [7:0]  ADDR      = 8'h00;
   logic [31:0] WDATA     = 32'h0000_0000;
   logic        WR        = 1'b0;
   logic        RD        = 1'b0;
   logic [31:0] RDATA;
   logic        IRQ;
   logic [31:0] got;
   int          err_total = 0;
   int          compares  = 0;
   int          cyc       = 0;
   wdt_if link ();
   wdt_dev #(.CNT_W(32)) u_wdt_dev (.MCLK(MCLK), .SRST(SRST), .LINK(link));
   wdt_host u_wdt_host (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .LINK(link));
   wdt_props u_wdt_props (.MCLK(MCLK), .SRST(SRST), .addr(link.addr), .wdata(link.wdata),
      .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .irq(link.irq),
      .rst_req(link.rst_req), .sys_rst(link.sys_rst));
   // Clock, 4 ns period
   always #2 MCLK = ~MCLK;
   ////////////////////////////////////////////////////////////////////////////
   // Hang guard and verdict
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         err_total++;
         $display("unexpected at %0t: run too long", $time);
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Software port cycles
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge MCLK);
      WR    <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge MCLK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge MCLK);
      RD   <= 1'b0;
      #1 d = RDATA;
   endtask
   // Command, then poll busy with a bound
   task automatic cmd(input int bitpos);
      int n;
      logic [31:0] b;
      wr_reg(HC_CMD_OFS, 32'h0000_0001 << bitpos);
      n = 0;
      do begin
         rd_reg(HC_CMD_OFS, b);
         n++;
      end while (b[0] !== 1'b0 && n < 20);
      chk({31'h0, b[0]}, 32'h0000_0000, "command stuck busy");
   endtask
   task automatic dev_ctrl(output logic [31:0] d);
      cmd(HC_CMD_READ);
      rd_reg(HC_RES_OFS, d);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_refuse();
      cmd(HC_CMD_ICLR);
      dev_ctrl(got);
      chk(got, 32'h0000_0000, "run set without keys");
      rd_reg(8'h3C, got);
      chk(got, 32'h0000_0000, "unmapped read");
      $display("test refuse done");
   endtask
   task automatic t_enable();
      wr_reg(HC_CFG_OFS, 32'h0000_0CFF);
      cmd(HC_CMD_EN);
      dev_ctrl(got);
      chk(got, 32'h0000_0DFF, "enable after keys");
      cmd(HC_CMD_DIS);
      dev_ctrl(got);
      chk(got, 32'h0000_0CFF, "plain disable");
      cmd(HC_CMD_EN);
      $display("test enable done");
   endtask
   task automatic t_timeout();
      int t0;
      int dt;
      wr_reg(HC_IEN_OFS, 32'h0000_0003);
      wr_reg(HC_ICLR_OFS, 32'h0000_0007);
      repeat (33000) @(posedge MCLK);
      t0 = cyc;
      cmd(HC_CMD_KICK);
      repeat (33000) @(posedge MCLK);
      rd_reg(HC_STAT_OFS, got);
      chk(got, 32'h0000_0004, "event despite kick");
      while (link.rst_req !== 1'b1 && cyc - t0 < 70000) @(posedge MCLK);
      dt = cyc - t0;
      chk({31'h0, dt >= 65536 && dt <= 65546}, 32'h0000_0001, "timeout length");
      repeat (4) @(posedge MCLK);
      rd_reg(HC_STAT_OFS, got);
      chk(got, 32'h0000_0007, "warning and reset events");
      chk({31'h0, IRQ}, 32'h0000_0001, "interrupt raised");
      wr_reg(HC_IEN_OFS, 32'h0000_0000);
      repeat (2) @(posedge MCLK);
      chk({31'h0, IRQ}, 32'h0000_0000, "interrupt masked");
      wr_reg(HC_ICLR_OFS, 32'h0000_0007);
      rd_reg(HC_STAT_OFS, got);
      chk(got, 32'h0000_0000, "status cleared");
      dev_ctrl(got);
      chk(got, 32'h8000_0900, "state after watchdog reset");
      cmd(HC_CMD_CCLR);
      dev_ctrl(got);
      chk(got, 32'h0000_0DFF, "cause cleared");
      $display("test timeout done");
   endtask
   task automatic t_por();
      @(posedge MCLK);
      SRST <= 1'b1;
      repeat (2) @(posedge MCLK);
      SRST <= 1'b0;
      dev_ctrl(got);
      chk(got, 32'h0000_0000, "power-on clears all");
      $display("test power-on done");
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge MCLK);
      SRST <= 1'b0;
      t_refuse();
      t_enable();
      t_timeout();
      t_por();
      give_verdict();
   end
endmodule
